// [src/smbus_word_pkg.sv]
// constants and carriers for the serial word-register slave
// assumes a core clock of 25 MHz and a separate link sampling clock
package smbus_word_pkg;
	localparam int CLK_HZ = 25_000_000;
	// inactivity period of the charging session, in seconds
	localparam longint TIMEOUT_S = 175;
	localparam longint TIMEOUT_CYCLES = TIMEOUT_S * CLK_HZ;
	// settle time after reset before commands are accepted, in microseconds
	localparam int POR_TIME_US = 10;
	localparam int POR_CYCLES = (POR_TIME_US * (CLK_HZ / 1_000_000) < 1) ? 1 :
		POR_TIME_US * (CLK_HZ / 1_000_000);
	localparam int TIMER_W = 33;
	localparam int POR_W = 16;
	// 7-bit slave address and its alias, the two control byte pairs
	localparam logic [6:0] SLAVE_ADDR = 7'h09;
	localparam logic [6:0] SLAVE_ADDR_ALT = 7'h0D;
	localparam logic DIR_READ = 1'h1;
	localparam logic [7:0] REG_CHARGE_CURRENT = 8'h14;
	localparam logic [7:0] REG_SYS_VOLTAGE = 8'h15;
	localparam logic [3:0] BIT_LAST = 4'h7;
	localparam logic [3:0] BIT_ACK = 4'h8;
	localparam logic [3:0] BIT_FIRST = 4'h0;
	localparam logic [7:0] PTR_STEP = 8'h01;
	localparam logic [15:0] WORD_RESET = 16'h0000;
	localparam int SYNC_LEN = 3;

	typedef struct packed {
		logic [7:0] addr;
		logic [15:0] data;
	} wr_req_t;

	typedef enum logic [2:0] {
		st_idle,
		st_ctrl,
		st_reg,
		st_wdata,
		st_rdata,
		st_ignore
	} link_state_t;
endpackage : smbus_word_pkg

// [src/smbus_word_register_slave.sv]
// serial management slave: start/stop detection, byte framing, word registers
// assumes scl/sda come from pins, link_clk is a free-running sampling clock
// much faster than scl, and the host spaces word writes by at least one byte
//
// Function
// - data line is sampled only on clock high; changes only while clock low
// - start is a data fall while the clock stays high
// - every byte takes nine clock pulses, ninth is the acknowledge slot
// - matching address is acknowledged by pulling data low for the ninth pulse
// - slave address 0001001, direction bit zero write, one read
// - mismatch or not ready leaves data released, giving a not-acknowledge
// - each register address byte is acknowledged low
// - bytes are eight bits, most significant first, then an acknowledge
// - word moves low byte first, high byte second, both directions
// - registers are sixteen bits; address steps on after each whole word written, and after each read word the host acknowledges
// - commands are taken only after power-on reset completes
// - only read-word and write-word sequences are supported; the code also lets either run on to further words at the next register address
// - device is slave only and never starts a transfer
// - control bytes 0x12/0x1A write and 0x13/0x1B read are answered
// - no write to voltage or current register for 175 s ends charging
`timescale 1ns/100ps
module smbus_word_register_slave #(
	parameter logic [smbus_word_pkg::TIMER_W-1:0] TIMEOUT_CYCLES =
		smbus_word_pkg::TIMER_W'(smbus_word_pkg::TIMEOUT_CYCLES),
	parameter logic [smbus_word_pkg::POR_W-1:0] POR_CYCLES =
		smbus_word_pkg::POR_W'(smbus_word_pkg::POR_CYCLES),
	parameter int DEPTH = 256
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic link_clk,
	input wire logic scl_i,
	input wire logic sda_i,
	output logic sda_o,
	output logic sda_oe,
	output logic [15:0] system_voltage_ceiling,
	output logic [15:0] battery_charge_current_setting,
	output logic charge_period_expired,
	output logic ready
);
	// ---------------- link domain ----------------
	logic [smbus_word_pkg::SYNC_LEN-1:0] scl_s_q;
	logic [smbus_word_pkg::SYNC_LEN-1:0] sda_s_q;
	logic scl_f_q;
	logic sda_f_q;
	logic scl_p_q;
	logic sda_p_q;
	logic start_ev;
	logic stop_ev;
	logic scl_rise;
	logic scl_fall;
	smbus_word_pkg::link_state_t state_q;
	logic [3:0] bit_cnt_q;
	logic [7:0] shift_q;
	logic [7:0] ptr_q;
	logic hi_q;
	logic [7:0] lo_byte_q;
	logic ack_drive_q;
	logic host_nack_q;
	logic drive_q;
	logic [15:0] rd_word_q;
	logic [7:0] rd_addr_q;
	logic rd_tog_q;
	smbus_word_pkg::wr_req_t wr_req_q;
	logic wr_tog_q;
	logic [1:0] rd_ack_s_q;
	logic rd_ack_p_q;
	logic [1:0] ready_s_q;
	logic tx_bit;
	logic addr_match;
	logic rise_seen_q;
	// core-domain words read here only through the toggle and level synchronisers
	logic rd_ack_tog_q;
	logic [15:0] rd_data_q;
	logic ready_q;

	// three-stage pin samplers; a level counts once the last two agree
	always_ff @(posedge link_clk or posedge rst) begin
		if (rst) begin
			scl_s_q <= '1;
			sda_s_q <= '1;
			scl_f_q <= 1'h1;
			sda_f_q <= 1'h1;
			scl_p_q <= 1'h1;
			sda_p_q <= 1'h1;
		end else begin
			scl_s_q <= {scl_s_q[1:0], scl_i};
			sda_s_q <= {sda_s_q[1:0], sda_i};
			if (scl_s_q[1] == scl_s_q[2]) begin
				scl_f_q <= scl_s_q[2];
			end
			if (sda_s_q[1] == sda_s_q[2]) begin
				sda_f_q <= sda_s_q[2];
			end
			scl_p_q <= scl_f_q;
			sda_p_q <= sda_f_q;
		end
	end

	// a data edge with the clock high is framing, never data
	assign start_ev = scl_f_q && scl_p_q && sda_p_q && !sda_f_q;
	assign stop_ev = scl_f_q && scl_p_q && !sda_p_q && sda_f_q;
	assign scl_rise = scl_f_q && !scl_p_q;
	assign scl_fall = !scl_f_q && scl_p_q;
	assign addr_match = ready_s_q[1] && ((shift_q[7:1] == smbus_word_pkg::SLAVE_ADDR) ||
		(shift_q[7:1] == smbus_word_pkg::SLAVE_ADDR_ALT));
	// byte sent msb first; low byte of the word before the high byte
	assign tx_bit = hi_q ? rd_word_q[4'(8 + 7 - bit_cnt_q)] : rd_word_q[3'(7 - bit_cnt_q)];

	// crossing syncs for the read answer and the ready level
	always_ff @(posedge link_clk or posedge rst) begin
		if (rst) begin
			rd_ack_s_q <= 2'h0;
			rd_ack_p_q <= 1'h0;
			ready_s_q <= 2'h0;
		end else begin
			rd_ack_s_q <= {rd_ack_s_q[0], rd_ack_tog_q};
			rd_ack_p_q <= rd_ack_s_q[1];
			ready_s_q <= {ready_s_q[0], ready_q};
		end
	end

	// fetched word; arrives long before the next scl rise
	always_ff @(posedge link_clk or posedge rst) begin
		if (rst) begin
			rd_word_q <= smbus_word_pkg::WORD_RESET;
		end else if (rd_ack_s_q[1] != rd_ack_p_q) begin
			rd_word_q <= rd_data_q;
		end
	end

	// byte framing and protocol sequencing
	always_ff @(posedge link_clk or posedge rst) begin
		if (rst) begin
			state_q <= smbus_word_pkg::st_idle;
			bit_cnt_q <= smbus_word_pkg::BIT_FIRST;
			shift_q <= 8'h00;
			ptr_q <= 8'h00;
			hi_q <= 1'h0;
			lo_byte_q <= 8'h00;
			ack_drive_q <= 1'h0;
			host_nack_q <= 1'h0;
			rd_addr_q <= 8'h00;
			rd_tog_q <= 1'h0;
			wr_req_q <= '0;
			wr_tog_q <= 1'h0;
			rise_seen_q <= 1'h0;
		end else if (start_ev) begin
			// restart is accepted too, so a read-word keeps its pointer
			state_q <= smbus_word_pkg::st_ctrl;
			bit_cnt_q <= smbus_word_pkg::BIT_FIRST;
			rise_seen_q <= 1'h0;
			hi_q <= 1'h0;
			ack_drive_q <= 1'h0;
		end else if (stop_ev) begin
			state_q <= smbus_word_pkg::st_idle;
			ack_drive_q <= 1'h0;
		end else if (state_q != smbus_word_pkg::st_idle && state_q != smbus_word_pkg::st_ignore)
		begin
			if (scl_rise) begin
				rise_seen_q <= 1'h1;
				if (bit_cnt_q != smbus_word_pkg::BIT_ACK) begin
					shift_q <= {shift_q[6:0], sda_f_q};
				end else begin
					host_nack_q <= sda_f_q;
				end
			// the fall that closes a start carries no bit, so it is not counted
			end else if (scl_fall && rise_seen_q) begin
				if (bit_cnt_q == smbus_word_pkg::BIT_LAST) begin
					// eighth bit done; ninth pulse is the acknowledge slot
					bit_cnt_q <= smbus_word_pkg::BIT_ACK;
					case (state_q)
						smbus_word_pkg::st_ctrl: begin
							if (addr_match) begin
								ack_drive_q <= 1'h1;
							end else begin
								state_q <= smbus_word_pkg::st_ignore;
							end
						end
						smbus_word_pkg::st_reg: begin
							ack_drive_q <= 1'h1;
							ptr_q <= shift_q;
							rd_addr_q <= shift_q;
							rd_tog_q <= !rd_tog_q;
							hi_q <= 1'h0;
						end
						smbus_word_pkg::st_wdata: begin
							ack_drive_q <= 1'h1;
							if (!hi_q) begin
								lo_byte_q <= shift_q;
								hi_q <= 1'h1;
							end else begin
								wr_req_q <= '{addr: ptr_q, data: {shift_q, lo_byte_q}};
								wr_tog_q <= !wr_tog_q;
								ptr_q <= ptr_q + smbus_word_pkg::PTR_STEP;
								hi_q <= 1'h0;
							end
						end
						default: begin
							ack_drive_q <= 1'h0;
						end
					endcase
				end else if (bit_cnt_q == smbus_word_pkg::BIT_ACK) begin
					bit_cnt_q <= smbus_word_pkg::BIT_FIRST;
					ack_drive_q <= 1'h0;
					case (state_q)
						smbus_word_pkg::st_ctrl: begin
							if (shift_q[0] == smbus_word_pkg::DIR_READ) begin
								state_q <= smbus_word_pkg::st_rdata;
								hi_q <= 1'h0;
							end else begin
								state_q <= smbus_word_pkg::st_reg;
							end
						end
						smbus_word_pkg::st_reg: begin
							state_q <= smbus_word_pkg::st_wdata;
						end
						smbus_word_pkg::st_rdata: begin
							if (host_nack_q) begin
								state_q <= smbus_word_pkg::st_ignore;
							end else if (!hi_q) begin
								hi_q <= 1'h1;
							end else begin
								// word done and host wants more: step and refetch
								hi_q <= 1'h0;
								ptr_q <= ptr_q + smbus_word_pkg::PTR_STEP;
								rd_addr_q <= ptr_q + smbus_word_pkg::PTR_STEP;
								rd_tog_q <= !rd_tog_q;
							end
						end
						default: begin
							state_q <= state_q;
						end
					endcase
				end else begin
					bit_cnt_q <= bit_cnt_q + 4'h1;
				end
			end
		end
	end

	// open-drain drive: only ever pulls low, updated one link cycle after the
	// scl fall so sda moves only while scl is low; no start is ever formed
	always_ff @(posedge link_clk or posedge rst) begin
		if (rst) begin
			drive_q <= 1'h0;
		end else begin
			drive_q <= ack_drive_q || (state_q == smbus_word_pkg::st_rdata &&
				bit_cnt_q != smbus_word_pkg::BIT_ACK && !tx_bit && !start_ev && !stop_ev);
		end
	end

	assign sda_o = 1'h0;
	assign sda_oe = drive_q;

	// ---------------- core domain ----------------
	logic [15:0] mem_q [DEPTH];
	logic [1:0] wr_tog_s_q;
	logic wr_tog_p_q;
	logic [1:0] rd_tog_s_q;
	logic rd_tog_p_q;
	logic [smbus_word_pkg::POR_W-1:0] por_cnt_q;
	logic [smbus_word_pkg::TIMER_W-1:0] idle_cnt_q;
	logic expired_q;
	logic wr_fire;
	logic rd_fire;
	logic timer_kick;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			wr_tog_s_q <= 2'h0;
			wr_tog_p_q <= 1'h0;
			rd_tog_s_q <= 2'h0;
			rd_tog_p_q <= 1'h0;
		end else begin
			wr_tog_s_q <= {wr_tog_s_q[0], wr_tog_q};
			wr_tog_p_q <= wr_tog_s_q[1];
			rd_tog_s_q <= {rd_tog_s_q[0], rd_tog_q};
			rd_tog_p_q <= rd_tog_s_q[1];
		end
	end

	// request words are held stable by the link until the next toggle
	assign wr_fire = wr_tog_s_q[1] != wr_tog_p_q;
	assign rd_fire = rd_tog_s_q[1] != rd_tog_p_q;
	assign timer_kick = wr_fire && (wr_req_q.addr == smbus_word_pkg::REG_CHARGE_CURRENT ||
		wr_req_q.addr == smbus_word_pkg::REG_SYS_VOLTAGE);

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			for (int i = 0; i < DEPTH; i++) begin
				mem_q[i] <= smbus_word_pkg::WORD_RESET;
			end
		end else if (wr_fire) begin
			mem_q[wr_req_q.addr] <= wr_req_q.data;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			rd_data_q <= smbus_word_pkg::WORD_RESET;
			rd_ack_tog_q <= 1'h0;
		end else if (rd_fire) begin
			rd_data_q <= mem_q[rd_addr_q];
			rd_ack_tog_q <= !rd_ack_tog_q;
		end
	end

	// not ready until the power-on settle time has run out
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			por_cnt_q <= '0;
			ready_q <= 1'h0;
		end else if (!ready_q) begin
			por_cnt_q <= por_cnt_q + 1'b1;
			ready_q <= (por_cnt_q + 1'b1) >= POR_CYCLES;
		end
	end

	// session timer; a kick in the expiry cycle wins and restarts it
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			idle_cnt_q <= '0;
			expired_q <= 1'h0;
		end else if (timer_kick) begin
			idle_cnt_q <= '0;
			expired_q <= 1'h0;
		end else if (!expired_q) begin
			idle_cnt_q <= idle_cnt_q + 1'b1;
			expired_q <= (idle_cnt_q + 1'b1) >= TIMEOUT_CYCLES;
		end
	end

	assign system_voltage_ceiling = mem_q[smbus_word_pkg::REG_SYS_VOLTAGE];
	assign battery_charge_current_setting = mem_q[smbus_word_pkg::REG_CHARGE_CURRENT];
	assign charge_period_expired = expired_q;
	assign ready = ready_q;
endmodule : smbus_word_register_slave

// [verif/smbus_host_model.sv]
// serial host model: makes the bus clock and pulls the data wire low
// assumes a pull-up on the data wire and the 25 MHz reference clock
`timescale 1ns/100ps
module smbus_host_model (
	input wire logic clk,
	input wire logic sda,
	output logic scl,
	output logic pull
);
	int qlen = 10;
	initial begin
		scl = 1'b1;
		pull = 1'b0;
	end
	// a quarter bit of ten cycles keeps setup and hold well above the pin filter
	task automatic qtr();
		repeat (qlen) @(posedge clk);
		#1;
	endtask : qtr
	task automatic start();
		pull = 1'b0;
		qtr();
		scl = 1'b1;
		qtr();
		pull = 1'b1;
		qtr();
		scl = 1'b0;
		qtr();
	endtask : start
	task automatic stop();
		pull = 1'b1;
		qtr();
		scl = 1'b1;
		qtr();
		pull = 1'b0;
		qtr();
	endtask : stop
	task automatic bit_io(input logic b, output logic r);
		pull = !b;
		qtr();
		scl = 1'b1;
		qtr();
		r = sda;
		qtr();
		scl = 1'b0;
		qtr();
	endtask : bit_io
	task automatic wbyte(input logic [7:0] b, output logic ack_n);
		logic r;
		for (int i = 7; i >= 0; i--) bit_io(b[i], r);
		bit_io(1'b1, ack_n);
	endtask : wbyte
	task automatic rbyte(input logic nack, output logic [7:0] d);
		logic r;
		for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
		bit_io(nack, r);
	endtask : rbyte
endmodule : smbus_host_model

// [verif/smbus_word_register_slave_props.sv]
// checker bound to the serial word-register slave top module
// assumes link_clk samples the pins far faster than the serial clock
`timescale 1ns/100ps
module smbus_word_register_slave_props #(
	parameter logic [32:0] TIMEOUT_CYCLES = 33'h0_0000_03E8,
	parameter logic [15:0] POR_CYCLES = 16'h0004,
	parameter int DEPTH = 256
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic link_clk,
	input wire logic scl_i,
	input wire logic sda_i,
	input wire logic sda_o,
	input wire logic sda_oe,
	input wire logic [15:0] system_voltage_ceiling,
	input wire logic [15:0] battery_charge_current_setting,
	input wire logic charge_period_expired,
	input wire logic ready
);
	logic [6:0] high_q;
	logic [15:0] por_q;
	logic [32:0] quiet_q;
	// a clock-high stretch longer than any slow bit means idle bus, so the slave has let go
	always_ff @(posedge link_clk or posedge rst) begin
		if (rst) begin
			high_q <= 7'h00;
		end else begin
			high_q <= scl_i ? high_q + {6'h00, high_q != 7'h7F} : 7'h00;
		end
	end
	// quiet time counts from a visible word change, so same-value writes are not seen
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			por_q <= 16'h0000;
			quiet_q <= 33'h0_0000_0000;
		end else begin
			por_q <= por_q + {15'h0000, por_q != 16'hFFFF};
			quiet_q <= ($changed(system_voltage_ceiling) || $changed(battery_charge_current_setting))
				? 33'h0_0000_0000 : quiet_q + 33'h0_0000_0001;
		end
	end
	a_pin_open_drain: assert property (@(posedge link_clk) disable iff (rst) !sda_o)
		else $error("data pin driven high");
	a_unready_silent: assert property (@(posedge link_clk) disable iff (rst) !ready |-> !sda_oe)
		else $error("data pulled before ready");
	a_change_clk_low: assert property (@(posedge link_clk) disable iff (rst)
		$changed(sda_oe) |-> !scl_i && !$past(scl_i, 3)) else $error("data moved near clock high");
	a_ack_held: assert property (@(posedge link_clk) disable iff (rst)
		$rose(scl_i) && sda_oe |=> sda_oe [*8]) else $error("pull dropped in clock high");
	a_idle_release: assert property (@(posedge link_clk) disable iff (rst)
		high_q == 7'h50 |-> !sda_oe) else $error("data held on idle bus");
	a_ready_delay: assert property (@(posedge clk) disable iff (rst)
		$rose(ready) |-> por_q >= POR_CYCLES - 1 && por_q <= POR_CYCLES + 1)
		else $error("ready at wrong time");
	a_expire_late: assert property (@(posedge clk) disable iff (rst)
		$rose(charge_period_expired) |-> quiet_q >= TIMEOUT_CYCLES - 2)
		else $error("expired too early");
	a_expire_due: assert property (@(posedge clk) disable iff (rst)
		quiet_q == TIMEOUT_CYCLES + 2 |-> charge_period_expired) else $error("expiry missing");
endmodule : smbus_word_register_slave_props
bind smbus_word_register_slave smbus_word_register_slave_props #(.TIMEOUT_CYCLES(TIMEOUT_CYCLES),
	.POR_CYCLES(POR_CYCLES), .DEPTH(DEPTH)) props (.clk(clk), .rst(rst), .link_clk(link_clk),
	.scl_i(scl_i), .sda_i(sda_i), .sda_o(sda_o), .sda_oe(sda_oe),
	.system_voltage_ceiling(system_voltage_ceiling),
	.battery_charge_current_setting(battery_charge_current_setting),
	.charge_period_expired(charge_period_expired), .ready(ready));

// [verif/smbus_word_register_slave_tb.sv]
// self-checking bench for the serial word-register slave
// assumes the host model and the bound checker are compiled with it
`timescale 1ns/100ps
module smbus_word_register_slave_tb;
	localparam logic [32:0] T_OUT = 33'h0_0000_0BB8;
	logic clk = 1'b0;
	logic link_clk = 1'b1;
	logic rst = 1'b1;
	logic scl, pull, sda_o, sda_oe, expired, ready;
	wire logic sda;
	logic [15:0] sysv, chg;
	int error_cnt = 0;
	int cmp_count = 0;
	// pull-up wins when nobody pulls
	assign sda = !(pull || sda_oe);
	always #20 clk = ~clk;
	always #15 link_clk = ~link_clk;
	smbus_word_register_slave #(.TIMEOUT_CYCLES(T_OUT), .POR_CYCLES(16'h0258)) dut (
		.clk(clk), .rst(rst), .link_clk(link_clk), .scl_i(scl), .sda_i(sda), .sda_o(sda_o),
		.sda_oe(sda_oe), .system_voltage_ceiling(sysv), .battery_charge_current_setting(chg),
		.charge_period_expired(expired), .ready(ready));
	smbus_host_model host (.clk(clk), .sda(sda), .scl(scl), .pull(pull));
	task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
		cmp_count++;
		if (got !== exp) begin
			error_cnt++;
			$display("FAIL %s expected %h seen %h", what, exp, got);
		end
	endtask : chk
	task automatic end_of_test();
		if (error_cnt == 0 && cmp_count > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask : end_of_test
	task automatic wr_word(input logic [7:0] ctl, input logic [7:0] ra, input logic [15:0] w);
		logic a0, a1, a2, a3;
		host.start();
		host.wbyte(ctl, a0);
		host.wbyte(ra, a1);
		host.wbyte(w[7:0], a2);
		host.wbyte(w[15:8], a3);
		host.stop();
		chk("write acks", 16'h0000, {12'h000, a0, a1, a2, a3});
	endtask : wr_word
	task automatic t_por();
		logic a;
		chk("ready early", 16'h0000, {15'h0000, ready});
		host.start();
		host.wbyte(8'h12, a);
		host.stop();
		chk("early nack", 16'h0001, {15'h0000, a});
		for (int n = 0; n < 1000 && ready !== 1'b1; n++) @(posedge clk);
		chk("ready", 16'h0001, {15'h0000, ready});
		if (ready !== 1'b1) end_of_test();
		repeat (8) @(posedge clk);
	endtask : t_por
	task automatic t_addr();
		logic [7:0] ctl [7] = '{8'h12, 8'h13, 8'h1A, 8'h1B, 8'h10, 8'h92, 8'h14};
		logic [7:0] d;
		logic a;
		for (int i = 0; i < 7; i++) begin
			host.start();
			host.wbyte(ctl[i], a);
			chk("ctl ack", {15'h0000, (ctl[i] & 8'hF6) != 8'h12}, {15'h0000, a});
			if (!a && ctl[i][0]) host.rbyte(1'b1, d);
			host.stop();
		end
	endtask : t_addr
	task automatic t_write();
		wr_word(8'h1A, smbus_word_pkg::REG_SYS_VOLTAGE, 16'h41A0);
		wr_word(8'h12, smbus_word_pkg::REG_CHARGE_CURRENT, 16'h8001);
		repeat (10) @(posedge clk);
		chk("voltage word", 16'h41A0, sysv);
		chk("current word", 16'h8001, chg);
	endtask : t_write
	task automatic t_read();
		logic [7:0] b [4];
		logic a0, a1, a2;
		host.qlen = 25;
		host.start();
		host.wbyte(8'h12, a0);
		host.wbyte(smbus_word_pkg::REG_CHARGE_CURRENT, a1);
		host.stop();
		host.start();
		host.wbyte(8'h1B, a2);
		for (int i = 0; i < 4; i++) host.rbyte(i == 3, b[i]);
		host.stop();
		host.qlen = 10;
		chk("read acks", 16'h0000, {13'h0000, a0, a1, a2});
		chk("read first", 16'h8001, {b[1], b[0]});
		chk("read next", 16'h41A0, {b[3], b[2]});
	endtask : t_read
	task automatic t_lone();
		logic a;
		host.start();
		host.wbyte(8'h12, a);
		host.wbyte(smbus_word_pkg::REG_CHARGE_CURRENT, a);
		host.wbyte(8'h55, a);
		host.stop();
		repeat (10) @(posedge clk);
		chk("lone byte", 16'h8001, chg);
	endtask : t_lone
	task automatic t_expire();
		int n;
		wr_word(8'h12, smbus_word_pkg::REG_SYS_VOLTAGE, 16'h1234);
		chk("fresh", 16'h0000, {15'h0000, expired});
		for (n = 0; n < T_OUT + 50 && expired !== 1'b1; n++) @(posedge clk);
		chk("expired", 16'h0001, {15'h0000, expired});
		if (expired !== 1'b1) end_of_test();
		chk("expiry time", 16'h0001, {15'h0000, n > T_OUT - 100 && n <= T_OUT});
		wr_word(8'h1A, smbus_word_pkg::REG_CHARGE_CURRENT, 16'h0F0F);
		chk("renewed", 16'h0000, {15'h0000, expired});
	endtask : t_expire
	initial begin
		repeat (16) @(posedge clk);
		#1;
		rst = 1'b0;
		t_por();
		t_addr();
		t_write();
		t_read();
		t_lone();
		t_expire();
		end_of_test();
	end
endmodule : smbus_word_register_slave_tb
